// [hdl/trs_align_if.sv]
// Carrier start alignment signals between control and aligner.
// Assumes both ends run on clk_sys.
interface trs_align_if;

  logic sync_en;
  logic carrier_en;
  logic demod_level;
  logic carrier_go;
  logic carrier_load;
  logic armed;

  modport ctl (
    output sync_en,
    output carrier_en,
    output demod_level,
    input  carrier_go,
    input  carrier_load,
    input  armed
  );

  modport aln (
    input  sync_en,
    input  carrier_en,
    input  demod_level,
    output carrier_go,
    output carrier_load,
    output armed
  );

endinterface : trs_align_if

// [hdl/trs_carrier_align.sv]
// Carrier timer start aligner.
// Assumes demod_level comes from logic on clk_sys; no synchroniser needed.
module trs_carrier_align (
  input wire logic clk_sys,
  input wire logic rstn,
  trs_align_if.aln al
);

  trs_pkg::trs_aln_state_t state_q;
  trs_pkg::trs_aln_state_t state_d;
  logic                    demod_q;
  logic                    demod_edge;
  logic                    go_q;
  logic                    load_q;
  logic                    load_d;

  ////////////////////////////////////////////////////////////////////////
  // Demodulated signal edge
  assign demod_edge = al.demod_level ^ demod_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      demod_q <= 1'b0;
    end else begin
      demod_q <= al.demod_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start sequencing
  always_comb begin
    state_d = state_q;
    load_d  = 1'b0;
    case (state_q)
      trs_pkg::TRS_ALN_IDLE: begin
        if (al.carrier_en && al.sync_en) begin
          state_d = trs_pkg::TRS_ALN_ARMED;
        end else if (al.carrier_en) begin
          state_d = trs_pkg::TRS_ALN_RUN;
          load_d  = 1'b1;
        end
      end
      trs_pkg::TRS_ALN_ARMED: begin
        if (!al.carrier_en) begin
          state_d = trs_pkg::TRS_ALN_IDLE;
        end else if (demod_edge) begin
          state_d = trs_pkg::TRS_ALN_RUN;
          load_d  = 1'b1; // Full reload gives an unshortened pulse
        end
      end
      trs_pkg::TRS_ALN_RUN: begin
        if (!al.carrier_en) begin
          state_d = trs_pkg::TRS_ALN_IDLE;
        end
      end
      default: begin
        state_d = trs_pkg::TRS_ALN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= trs_pkg::TRS_ALN_IDLE;
      go_q    <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      go_q    <= (state_d == trs_pkg::TRS_ALN_RUN);
      load_q  <= load_d;
    end
  end

  assign al.carrier_go   = go_q;
  assign al.carrier_load = load_q;
  assign al.armed        = (state_q == trs_pkg::TRS_ALN_ARMED);

endmodule : trs_carrier_align

// [hdl/trs_params.svh]
// Offsets, bit positions and reset values of the timer run control block.
// Assumes 32-bit APB data with one register per aligned word.
`ifndef TRS_PARAMS_SVH
`define TRS_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define TRS_IDX_RUN_CTL   3
`define TRS_IDX_STATUS    4
`define TRS_ADDR_MUL      4

////////////////////////////////////////////////////////////////////////////
// Run control fields
`define TRS_BIT_DEMOD     0
`define TRS_BIT_CARRIER   1
`define TRS_BIT_SYNC      2
`define TRS_RSVD_LSB      3
`define TRS_RSVD_MSB      7
`define TRS_RSVD_ONES     5'h1f

////////////////////////////////////////////////////////////////////////////
// Status fields
`define TRS_STAT_ARMED    0
`define TRS_STAT_GO       1

////////////////////////////////////////////////////////////////////////////
// Reset values
`define TRS_RST_RUN       1'b0
`define TRS_RST_SYNC      1'b0
`define TRS_RST_DATA      32'h0000_0000

`endif

// [hdl/trs_pkg.sv]
// Types of the timer run control block.
// Assumes trs_params.svh for all numeric constants.
package trs_pkg;

  typedef enum logic [1:0] {
    TRS_REG_NONE,
    TRS_REG_RUN_CTL,
    TRS_REG_STATUS
  } trs_reg_t;

  typedef enum logic [1:0] {
    TRS_ALN_IDLE,
    TRS_ALN_ARMED,
    TRS_ALN_RUN
  } trs_aln_state_t;

endpackage : trs_pkg

// [hdl/trs_run_ctl.sv]
// Timer run control register with APB slave and carrier sync start.
// Assumes smr_wake and demod_level come from logic on clk_sys.
//
// Functional notes
// - Upper five bits ignore writes and always read as ones.
// - Sync enable bit turns synchronised carrier start on; resets to zero.
// - Sync enable keeps its value across stop-mode recovery; full reset only.
// - Carrier run bit starts or stops the 8-bit timer; reads state; resets 0.
// - Demodulation run bit starts or stops 16-bit timer; reads state; resets 0.
// - In sync mode first carrier pulse aligns to demod signal, full length.
//
// Register access over APB was left to the implementer.
`include "trs_params.svh"

module trs_run_ctl #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              smr_wake,
  input  wire logic              demod_level,
  output logic                   carrier_en,
  output logic                   demod_en,
  output logic                   sync_en,
  output logic                   carrier_go,
  output logic                   carrier_load
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic trs_pkg::trs_reg_t reg_sel(
    input logic [ADDR_W-1:0] addr
  );
    if (addr == ADDR_W'(`TRS_IDX_RUN_CTL * `TRS_ADDR_MUL)) begin
      reg_sel = trs_pkg::TRS_REG_RUN_CTL;
    end else if (addr == ADDR_W'(`TRS_IDX_STATUS * `TRS_ADDR_MUL)) begin
      reg_sel = trs_pkg::TRS_REG_STATUS;
    end else begin
      reg_sel = trs_pkg::TRS_REG_NONE;
    end
  endfunction : reg_sel

  trs_align_if al ();

  logic        pready_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        access;
  logic        commit;
  logic        wr_ctl;
  logic        carrier_en_q;
  logic        demod_en_q;
  logic        sync_en_q;
  logic        go_q;
  logic        load_q;
  logic [7:0]  ctl_rd;
  logic [7:0]  stat_rd;

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer from flops
  assign access = psel & penable;
  assign commit = access & pready_q;
  assign wr_ctl = commit & pwrite & pstrb[0]
                & (reg_sel(paddr) == trs_pkg::TRS_REG_RUN_CTL);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback images
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[`TRS_RSVD_MSB:`TRS_RSVD_LSB] = `TRS_RSVD_ONES;
    ctl_rd[`TRS_BIT_SYNC]    = sync_en_q;
    ctl_rd[`TRS_BIT_CARRIER] = carrier_en_q;
    ctl_rd[`TRS_BIT_DEMOD]   = demod_en_q;
  end

  always_comb begin
    stat_rd = 8'h00;
    stat_rd[`TRS_STAT_ARMED] = al.armed;
    stat_rd[`TRS_STAT_GO]    = al.carrier_go;
  end

  always_comb begin
    prdata_d = `TRS_RST_DATA;
    case (reg_sel(paddr))
      trs_pkg::TRS_REG_RUN_CTL: begin
        prdata_d = {24'h00_0000, ctl_rd};
      end
      trs_pkg::TRS_REG_STATUS: begin
        prdata_d = {24'h00_0000, stat_rd};
      end
      default: begin
        prdata_d = `TRS_RST_DATA;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_q  <= `TRS_RST_DATA;
      pslverr_q <= 1'b0;
    end else if (access & ~pready_q) begin
      prdata_q  <= pwrite ? `TRS_RST_DATA : prdata_d;
      pslverr_q <= (reg_sel(paddr) == trs_pkg::TRS_REG_NONE);
    end else begin
      prdata_q  <= `TRS_RST_DATA;
      pslverr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run bits: cleared by reset and by stop-mode recovery
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      carrier_en_q <= `TRS_RST_RUN;
      demod_en_q   <= `TRS_RST_RUN;
    end else if (smr_wake) begin
      carrier_en_q <= `TRS_RST_RUN;
      demod_en_q   <= `TRS_RST_RUN;
    end else if (wr_ctl) begin
      carrier_en_q <= pwdata[`TRS_BIT_CARRIER];
      demod_en_q   <= pwdata[`TRS_BIT_DEMOD];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync enable: survives stop-mode recovery
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_en_q <= `TRS_RST_SYNC;
    end else if (wr_ctl) begin
      sync_en_q <= pwdata[`TRS_BIT_SYNC];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Carrier start alignment
  assign al.sync_en     = sync_en_q;
  assign al.carrier_en  = carrier_en_q & ~smr_wake;
  assign al.demod_level = demod_level;

  trs_carrier_align u_align (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .al      (al.aln)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      go_q   <= 1'b0;
      load_q <= 1'b0;
    end else begin
      go_q   <= al.carrier_go;
      load_q <= al.carrier_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign carrier_en   = carrier_en_q;
  assign demod_en     = demod_en_q;
  assign sync_en      = sync_en_q;
  assign carrier_go   = go_q;
  assign carrier_load = load_q;

endmodule : trs_run_ctl

// [test/tb_top.sv]
// Self-checking bench for the timer run control block.
// Assumes pready arrives in the second access cycle of APB.
`include "trs_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_RC = 12'(`TRS_IDX_RUN_CTL * `TRS_ADDR_MUL);
  localparam logic [11:0] A_ST = 12'(`TRS_IDX_STATUS * `TRS_ADDR_MUL);
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        smr_wake = 1'b0;
  logic        demod_level = 1'b0;
  logic        pready, pslverr, carrier_en, demod_en, sync_en;
  logic        carrier_go, carrier_load, err;
  logic [31:0] prdata, r;
  int          n_errors = 0;
  int          checked = 0;
  always #5 clk_sys = ~clk_sys;
  trs_run_ctl trs_run_ctl_i (
    .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .smr_wake(smr_wake), .demod_level(demod_level),
    .carrier_en(carrier_en), .demod_en(demod_en), .sync_en(sync_en),
    .carrier_go(carrier_go), .carrier_load(carrier_load));
  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      results();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rchk(input string nm, input logic [31:0] e);
    apb(1'b0, A_RC, 32'h0);
    chk(nm, e, r);
  endtask : rchk
  task automatic wait_go();
    int i;
    i = 0;
    while (carrier_go !== 1'b1 && i < 20) begin
      @(posedge clk_sys);
      i++;
    end
    chk("carrier_go", 32'h1, {31'h0, carrier_go});
    chk("carrier_load", 32'h1, {31'h0, carrier_load});
    if (i >= 20) begin
      results();
    end
  endtask : wait_go
  ////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rchk("reset", 32'hf8);
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, A_RC, 32'h50 | v);
      rchk("run_ctl", 32'hf8 | v);
    end
    chk("pins", 32'h7, {29'h0, sync_en, carrier_en, demod_en});
    repeat (4) @(posedge clk_sys);
    chk("armed_go", 32'h0, {31'h0, carrier_go});
    apb(1'b0, A_ST, 32'h0);
    chk("status_armed", 32'h1, r);
    demod_level <= 1'b1;
    wait_go();
    apb(1'b0, A_ST, 32'h0);
    chk("status_run", 32'h2, r);
    smr_wake <= 1'b1;
    @(posedge clk_sys);
    smr_wake <= 1'b0;
    rchk("wake", 32'hfc);
    chk("go_stop", 32'h0, {31'h0, carrier_go});
    pstrb <= 4'he;
    apb(1'b1, A_RC, 32'h3);
    pstrb <= 4'hf;
    rchk("no_strobe", 32'hfc);
    apb(1'b1, A_RC, 32'h2);
    wait_go();
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, r);
    apb(1'b1, A_RC, 32'h7);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rchk("rereset", 32'hf8);
    results();
  end
endmodule : tb_top

// [test/trs_run_ctl_sva.sv]
// Checker for the timer run control block.
// Assumes trs_params.svh and the ports of trs_run_ctl only.
`include "trs_params.svh"
module trs_run_ctl_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              smr_wake,
  input wire logic              demod_level,
  input wire logic              carrier_en,
  input wire logic              demod_en,
  input wire logic              sync_en,
  input wire logic              carrier_go,
  input wire logic              carrier_load
);
  localparam logic [ADDR_W-1:0] A_RC =
    ADDR_W'(`TRS_IDX_RUN_CTL * `TRS_ADDR_MUL);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // Steps
  sequence s_rd;
    pready && !pwrite && paddr == A_RC;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite && paddr == A_RC && pstrb[0] &&
    !smr_wake;
  endsequence
  sequence s_plain;
    $rose(carrier_en) && !sync_en ##1 carrier_en;
  endsequence
  sequence s_pulse;
    carrier_load ##1 !carrier_load;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // Properties
  a_rsvd_ones: assert property (s_rd |-> prdata[31:3] == 29'h1f)
    else $error("reserved bits not read as ones");
  a_rd_fields: assert property (s_rd |->
    prdata[2:0] == {sync_en, carrier_en, demod_en})
    else $error("run control readback wrong");
  a_wr_take: assert property (s_wr |=>
    {sync_en, carrier_en, demod_en} == $past(pwdata[2:0]))
    else $error("run control write not taken");
  a_wake_stop: assert property (smr_wake |=>
    !carrier_en && !demod_en)
    else $error("wake left a timer running");
  a_sync_keep: assert property (smr_wake &&
    !(psel && penable && pready && pwrite) |=> $stable(sync_en))
    else $error("sync changed on wake");
  a_plain_start: assert property (s_plain |=>
    carrier_go && carrier_load)
    else $error("plain carrier start late");
  a_sync_align: assert property ($rose(carrier_go) &&
    $past(sync_en, 2) |-> $past(demod_level, 2) != $past(demod_level, 3))
    else $error("sync start not on demod change");
  a_load_pulse: assert property ($rose(carrier_go) |-> s_pulse)
    else $error("carrier load not one cycle");
  a_go_hold: assert property (carrier_go && carrier_en |=> carrier_go)
    else $error("carrier pulse cut short");
endmodule : trs_run_ctl_sva

bind trs_run_ctl trs_run_ctl_sva #(.ADDR_W(ADDR_W)) trs_run_ctl_sva_i (
  .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .smr_wake(smr_wake), .demod_level(demod_level),
  .carrier_en(carrier_en), .demod_en(demod_en), .sync_en(sync_en),
  .carrier_go(carrier_go), .carrier_load(carrier_load));
